// *** dual_i2s_audio_port.sv ***
`default_nettype none
`include "i2s_port_defines.svh"
module dual_i2s_audio_port
  import i2s_port_pkg::*;
#(
  parameter bit SHORT_RANGE = 1'b0,
  parameter int SLOT_MAX    = 64
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        link_clk,
  input  wire logic        host_if_found,
  input  wire logic        map_req,
  input  wire logic        master_en,
  input  wire logic        mono_en,
  input  wire logic        msb_on_edge,
  input  wire logic        full_duplex_en,
  input  wire logic        tx_dir,
  input  wire logic        clk_inv,
  input  wire logic        ws_inv,
  input  wire logic        din_inv,
  input  wire logic        dout_inv,
  input  wire logic [9:0]  rate_steps,
  input  wire logic [7:0]  slot_bits,
  input  wire logic [7:0]  ws_rise_pos,
  input  wire logic        idle_drive_low,
  input  wire logic        idle_clk_stop,
  input  wire logic [15:0] tx_left,
  input  wire logic [15:0] tx_right,
  output wire logic        tx_taken,
  output wire logic [15:0] rx_left,
  output wire logic [15:0] rx_right,
  output wire logic        rx_valid,
  output wire logic        port_live,
  output wire logic        bclk_ref,
  output wire logic        bclk_o,
  output wire logic        bclk_oe_n,
  input  wire logic        ws_i,
  output wire logic        ws_o,
  output wire logic        ws_oe_n,
  input  wire logic        din_i,
  output wire logic        dout_o,
  output wire logic        dout_oe_n
);

  localparam logic [15:0] WS_LO_BCLK = `WS_MIN_KHZ * `MASTER_RATIO;
  localparam logic [15:0] WS_HI_BCLK = `WS_MAX_KHZ * `MASTER_RATIO;
  localparam logic [15:0] BC_LO_KHZ  = (`BC_BCLK_MIN_KHZ > WS_LO_BCLK) ?
                                       `BC_BCLK_MIN_KHZ : WS_LO_BCLK;
  localparam logic [15:0] BC_HI_KHZ  = (`BC_BCLK_MAX_KHZ < WS_HI_BCLK) ?
                                       `BC_BCLK_MAX_KHZ : WS_HI_BCLK;
  localparam logic [15:0] LO_STEPS   = (SHORT_RANGE ? `SR_BCLK_MIN_KHZ : BC_LO_KHZ)
                                       / `STEP_KHZ;
  localparam logic [15:0] HI_STEPS   = (SHORT_RANGE ? `SR_BCLK_MAX_KHZ : BC_HI_KHZ)
                                       / `STEP_KHZ;

  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    logic [15:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction : clamp16

  // Splits a frame position into channel half and position within it
  function automatic logic [8:0] split_pos(input logic [7:0] pos,
                                           input logic [7:0] rise);
    logic [8:0] r;
    r = {1'b0, pos};
    if (pos >= rise) begin
      r = {1'b1, pos - rise};
    end
    return r;
  endfunction : split_pos

  // Moves a frame position back by the one-clock select lead, so that a
  // word's last bit, which falls after the select edge, stays in its half
  function automatic logic [7:0] shift_pos(input logic [7:0] p,
                                           input logic       lj,
                                           input logic [7:0] frame);
    logic [7:0] r;
    r = p;
    if (!lj) begin
      r = (p == 8'h00) ? frame - 8'h01 : p - 8'h01;
    end
    return r;
  endfunction : shift_pos

  function automatic logic in_sample(input logic [7:0] p, input logic lj);
    logic [7:0] dly;
    dly = lj ? 8'h00 : 8'h01;
    return (p >= dly) && ((p - dly) < `SAMPLE_BITS);
  endfunction : in_sample

  function automatic logic [7:0] bit_idx(input logic [7:0] p, input logic lj);
    logic [7:0] dly;
    dly = lj ? 8'h00 : 8'h01;
    return p - dly;
  endfunction : bit_idx

  // ---------------- System clock domain ----------------
  main_s       m_q;
  main_s       m_d;
  logic [15:0] slot_w;
  logic [15:0] rise_w;
  logic        live_w;
  logic        wide_w;
  logic        gate_w;
  link_s       l_q;
  link_s       l_d;

  rate_if rt ();

  i2s_rate_gen u_rate (
    .mclk    (mclk),
    .reset_n (reset_n),
    .rt      (rt)
  );

  assign rt.steps = m_q.steps;
  assign rt.run   = m_q.cfg.master & m_q.cfg.live;

  always_comb begin
    m_d          = m_q;
    m_d.tx_taken = 1'b0;
    m_d.rx_valid = 1'b0;
    m_d.take_s   = {m_q.take_s[1:0], l_q.take_tgl};
    m_d.rxt_s    = {m_q.rxt_s[1:0], l_q.rx_tgl};
    m_d.idle_s   = {m_q.idle_s[0], l_q.idle};
    if (map_req && host_if_found) begin
      m_d.mapped = 1'b1;
    end
    live_w = host_if_found && (!SHORT_RANGE || m_q.mapped);
    slot_w = SHORT_RANGE ? clamp16(16'(slot_bits), 16'(`SAMPLE_BITS), 16'(SLOT_MAX))
                         : 16'(`SAMPLE_BITS);
    wide_w = SHORT_RANGE && (slot_w > 16'(`SAMPLE_BITS));
    rise_w = wide_w ? clamp16(16'(ws_rise_pos), 16'h0001, (slot_w << 1) - 16'h0001)
                    : slot_w;
    m_d.steps = 10'(clamp16(16'(rate_steps), LO_STEPS, HI_STEPS));
    m_d.cfg.master   = master_en;
    m_d.cfg.mono     = mono_en;
    m_d.cfg.lj       = msb_on_edge;
    m_d.cfg.tx_on    = (SHORT_RANGE && full_duplex_en) || tx_dir;
    m_d.cfg.rx_on    = (SHORT_RANGE && full_duplex_en) || !tx_dir;
    m_d.cfg.idle_hiz = wide_w && !idle_drive_low;
    m_d.cfg.dout_inv = dout_inv;
    m_d.cfg.din_inv  = din_inv;
    m_d.cfg.ws_inv   = ws_inv;
    m_d.cfg.live     = live_w;
    m_d.cfg.clk_stop = wide_w && idle_clk_stop;
    m_d.cfg.slot     = slot_w[7:0];
    m_d.cfg.rise     = rise_w[7:0];
    // Words cross by handshake: the link takes them a whole frame later
    if (m_q.take_s[1] ^ m_q.take_s[2]) begin
      m_d.txl      = tx_left;
      m_d.txr      = tx_right;
      m_d.tx_taken = 1'b1;
    end
    if (m_q.rxt_s[1] ^ m_q.rxt_s[2]) begin
      m_d.rxl      = l_q.rxl;
      m_d.rxr      = l_q.rxr;
      m_d.rx_valid = 1'b1;
    end
    // The stop follows the link through a synchroniser, so it lags by a
    // few system clocks; at the top rates it may cut one idle half period late.
    gate_w        = m_q.cfg.clk_stop && m_q.idle_s[1];
    m_d.bclk_pin  = (rt.ref_level & ~gate_w) ^ clk_inv;
    // Enables follow the same edge as port_live, so the clock and select pins never outlive it
    m_d.bclk_oe_n = !(master_en && live_w);
    m_d.ws_oe_n   = !(master_en && live_w);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      m_q           <= '0;
      m_q.bclk_oe_n <= 1'b1;
      m_q.ws_oe_n   <= 1'b1;
    end else begin
      m_q <= m_d;
    end
  end

  // ---------------- Link clock domain ----------------
  // Clock polarity must only change while the port is off the pins.
  wire logic   eclk;
  logic [1:0]  lrst_q;
  cfg_s        c;
  logic        ws_s;
  logic [7:0]  c_now;
  logic [7:0]  cnt_n;
  logic [7:0]  frame_w;
  logic [8:0]  hp_rx;
  logic [8:0]  hp_tx;
  logic        act_n;
  logic [15:0] sh_w;
  logic [15:0] word_w;
  logic [7:0]  bn;
  pin_s        p_q;

  assign eclk = link_clk ^ clk_inv;

  always_ff @(posedge eclk or negedge reset_n) begin
    if (!reset_n) begin
      lrst_q <= 2'b00;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end

  always_comb begin
    l_d      = l_q;
    l_d.cfg1 = m_q.cfg;
    l_d.cfg2 = l_q.cfg1;
    c        = l_q.cfg2;
    frame_w  = {c.slot[6:0], 1'b0};
    ws_s     = ws_i ^ c.ws_inv;
    l_d.ws_prev = ws_s;
    c_now    = l_q.cnt;
    if (!c.master && (ws_s != l_q.ws_prev)) begin
      c_now = ws_s ? c.rise : `CNT_RST;
    end
    // Receive the bit presented at this edge
    hp_rx = split_pos(shift_pos(c_now, c.lj, frame_w), c.rise);
    sh_w  = {l_q.rx_sh[14:0], din_i ^ c.din_inv};
    if (c.live && c.rx_on && in_sample(hp_rx[7:0], 1'b1)) begin
      l_d.rx_sh = sh_w;
      if (bit_idx(hp_rx[7:0], 1'b1) == `SAMPLE_BITS - 8'h01) begin
        if (hp_rx[8]) begin
          l_d.rxr    = sh_w;
          l_d.rx_tgl = ~l_q.rx_tgl;
        end else begin
          l_d.rxl = sh_w;
        end
      end
    end
    cnt_n   = (c_now >= frame_w - 8'h01) ? `CNT_RST : c_now + 8'h01;
    l_d.cnt = cnt_n;
    // Reload where the next left word starts, after the old right LSB left
    if (cnt_n == (c.lj ? `CNT_RST : 8'h01)) begin
      l_d.txl      = m_q.txl;
      l_d.txr      = c.mono ? m_q.txl : m_q.txr;
      l_d.take_tgl = ~l_q.take_tgl;
    end
    // Prepare the bit launched on the coming falling edge
    hp_tx  = split_pos(shift_pos(cnt_n, c.lj, frame_w), c.rise);
    act_n  = in_sample(hp_tx[7:0], 1'b1);
    bn     = bit_idx(hp_tx[7:0], 1'b1);
    word_w = hp_tx[8] ? l_d.txr : l_d.txl;
    l_d.tx_bit = act_n ? word_w[4'(`SAMPLE_BITS - 8'h01 - bn)] : 1'b0;
    l_d.tx_drv = c.live && c.tx_on && (act_n || !c.idle_hiz);
    l_d.ws_bit = cnt_n >= c.rise;
    l_d.idle   = !act_n;
  end

  always_ff @(posedge eclk or negedge lrst_q[1]) begin
    if (!lrst_q[1]) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // Output launch on the opposite edge so the partner samples mid-bit
  always_ff @(negedge eclk or negedge lrst_q[1]) begin
    if (!lrst_q[1]) begin
      p_q.dout      <= 1'b0;
      p_q.dout_oe_n <= 1'b1;
      p_q.ws        <= 1'b0;
    end else begin
      p_q.dout      <= l_q.tx_bit ^ l_q.cfg2.dout_inv;
      p_q.dout_oe_n <= !l_q.tx_drv;
      p_q.ws        <= l_q.ws_bit ^ l_q.cfg2.ws_inv;
    end
  end

  assign tx_taken  = m_q.tx_taken;
  assign rx_left   = m_q.rxl;
  assign rx_right  = m_q.rxr;
  assign rx_valid  = m_q.rx_valid;
  assign port_live = m_q.cfg.live;
  assign bclk_ref  = rt.ref_level;
  assign bclk_o    = m_q.bclk_pin;
  assign bclk_oe_n = m_q.bclk_oe_n;
  assign ws_o      = p_q.ws;
  assign ws_oe_n   = m_q.ws_oe_n;
  assign dout_o    = p_q.dout;
  assign dout_oe_n = p_q.dout_oe_n;

endmodule : dual_i2s_audio_port
`default_nettype wire

// *** i2s_port_defines.svh ***
`ifndef I2S_PORT_DEFINES_SVH
`define I2S_PORT_DEFINES_SVH

// System clock, 40 MHz
`define MCLK_HZ            32'h0262_5A00
// Bit clock rate step in Hz and in kHz
`define STEP_HZ            32'h0000_1F40
`define STEP_KHZ           16'h0008
// Sample word length in bits
`define SAMPLE_BITS        8'h10
// Master ratio of bit clock to word select
`define MASTER_RATIO       16'h0020
// Broadcast variant bit clock range, kHz
`define BC_BCLK_MIN_KHZ    16'h00C0
`define BC_BCLK_MAX_KHZ    16'h1800
// Short-range variant bit clock range, kHz
`define SR_BCLK_MIN_KHZ    16'h0100
`define SR_BCLK_MAX_KHZ    16'h0FA0
// Sample (word select) rate range, kHz
`define WS_MIN_KHZ         16'h0008
`define WS_MAX_KHZ         16'h00C0
// Reset values
`define CNT_RST            8'h00
`define WORD_RST           16'h0000
`define ACC_RST            32'h0000_0000

`endif

// *** i2s_port_pkg.sv ***
`default_nettype none
package i2s_port_pkg;

  typedef struct packed {
    logic       master;
    logic       mono;
    logic       lj;
    logic       tx_on;
    logic       rx_on;
    logic       idle_hiz;
    logic       dout_inv;
    logic       din_inv;
    logic       ws_inv;
    logic       live;
    logic       clk_stop;
    logic [7:0] slot;
    logic [7:0] rise;
  } cfg_s;

  typedef struct packed {
    logic [31:0] acc;
    logic        lvl;
  } rate_s;

  typedef struct packed {
    cfg_s        cfg;
    logic [9:0]  steps;
    logic        mapped;
    logic [15:0] txl;
    logic [15:0] txr;
    logic [2:0]  take_s;
    logic [2:0]  rxt_s;
    logic [1:0]  idle_s;
    logic        tx_taken;
    logic [15:0] rxl;
    logic [15:0] rxr;
    logic        rx_valid;
    logic        bclk_pin;
    logic        bclk_oe_n;
    logic        ws_oe_n;
  } main_s;

  typedef struct packed {
    cfg_s        cfg1;
    cfg_s        cfg2;
    logic [7:0]  cnt;
    logic        ws_prev;
    logic        ws_bit;
    logic        tx_bit;
    logic        tx_drv;
    logic        idle;
    logic [15:0] txl;
    logic [15:0] txr;
    logic [15:0] rx_sh;
    logic [15:0] rxl;
    logic [15:0] rxr;
    logic        take_tgl;
    logic        rx_tgl;
  } link_s;

  typedef struct packed {
    logic dout;
    logic dout_oe_n;
    logic ws;
  } pin_s;

endpackage : i2s_port_pkg
`default_nettype wire

// *** rate_if.sv ***
`default_nettype none
interface rate_if;
  logic [9:0] steps;
  logic       run;
  logic       ref_level;
  modport gen  (input steps, input run, output ref_level);
  modport user (output steps, output run, input ref_level);
endinterface : rate_if
`default_nettype wire

// *** i2s_rate_gen.sv ***
`default_nettype none
`include "i2s_port_defines.svh"
module i2s_rate_gen
  import i2s_port_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset_n,
  rate_if.gen       rt
);

  rate_s       q;
  rate_s       d;
  logic [31:0] inc;
  logic [31:0] sum;

  // Phase accumulator: one toggle per half bit period, so the mean rate
  // is exact at any 8 kHz step; edges jitter by one system clock.
  always_comb begin
    inc = 32'(rt.steps) * `STEP_HZ * 32'h0000_0002;
    sum = q.acc + inc;
    d   = q;
    if (rt.run) begin
      if (sum >= `MCLK_HZ) begin
        d.acc = sum - `MCLK_HZ;
        d.lvl = ~q.lvl;
      end else begin
        d.acc = sum;
      end
    end else begin
      d.acc = `ACC_RST;
      d.lvl = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rt.ref_level = q.lvl;

endmodule : i2s_rate_gen
`default_nettype wire

// *** i2s_port_checker_assertions.sv ***
`default_nettype none
module i2s_port_checker
#(
  parameter bit SHORT_RANGE = 1'b0,
  parameter int SLOT_MAX    = 64
) (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        link_clk,
  input wire logic        host_if_found,
  input wire logic        master_en,
  input wire logic        tx_dir,
  input wire logic        tx_taken,
  input wire logic        rx_valid,
  input wire logic [15:0] rx_left,
  input wire logic        port_live,
  input wire logic        bclk_oe_n,
  input wire logic        ws_o,
  input wire logic        ws_oe_n,
  input wire logic        dout_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  sequence s_host_held;
    host_if_found [*2];
  endsequence
  sequence s_master_held;
    (port_live && master_en) [*3];
  endsequence
  a_pins_off_dead: assert property (@(posedge mclk) disable iff (!reset_n)
    !port_live |-> bclk_oe_n && ws_oe_n) else $error("pins driven while off");
  a_live_after_host: assert property (@(posedge mclk) disable iff (!reset_n)
    s_host_held |=> port_live) else $error("port did not go live");
  a_live_needs_host: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(port_live) |-> $past(host_if_found)) else $error("live without host");
  a_master_drives: assert property (@(posedge mclk) disable iff (!reset_n)
    s_master_held |-> !bclk_oe_n && !ws_oe_n) else $error("master not driving");
  a_slave_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
    (!master_en) [*3] |-> bclk_oe_n && ws_oe_n) else $error("slave drives clock");
  a_half_duplex_rx: assert property (@(posedge link_clk) disable iff (!reset_n)
    (!tx_dir) [*6] |-> dout_oe_n) else $error("output driven while receiving");
  a_ws_half_len: assert property (@(posedge link_clk) disable iff (!reset_n)
    !ws_oe_n && $rose(ws_o) |-> ##16 $fell(ws_o)) else $error("select half not 16");
  a_tx_pulse_once: assert property (@(posedge mclk) disable iff (!reset_n)
    tx_taken |=> !tx_taken [*8]) else $error("word taken twice");
  a_rx_word_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    !rx_valid |-> $stable(rx_left)) else $error("rx word moved");
endmodule : i2s_port_checker
bind dual_i2s_audio_port i2s_port_checker #(.SHORT_RANGE(SHORT_RANGE), .SLOT_MAX(SLOT_MAX)) chk (
  .mclk(mclk), .reset_n(reset_n), .link_clk(link_clk), .host_if_found(host_if_found),
  .master_en(master_en), .tx_dir(tx_dir), .tx_taken(tx_taken), .rx_valid(rx_valid),
  .rx_left(rx_left), .port_live(port_live), .bclk_oe_n(bclk_oe_n), .ws_o(ws_o),
  .ws_oe_n(ws_oe_n), .dout_oe_n(dout_oe_n));
`default_nettype wire

// *** i2s_codec_model.sv ***
`default_nettype none
module i2s_codec_model (
  output logic        bclk,
  output logic        ws,
  output logic        din,
  input  wire logic   dout,
  input  wire logic   ext_clk,
  input  wire logic   ext_ws,
  input  wire logic   use_ext,
  input  wire logic [15:0] send_l,
  input  wire logic [15:0] send_r,
  output logic [15:0] got_l,
  output logic [15:0] got_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0]  pos_q = 5'h1F;
  logic [4:0]  nxt;
  logic [15:0] tx_sh = 16'h0000;
  logic [15:0] rx_sh = 16'h0000;
  logic        ws_q  = 1'b0;
  // As slave to the port, the codec receives on the port's clock and select; it still sends on its own bclk
  wire logic   sclk    = use_ext ? ext_clk : bclk;
  wire logic   ws_seen = use_ext ? ext_ws : ws;
  // Free-running clock with its own phase, as a codec keeps it going between frames
  initial begin
    bclk = 1'b0;
    ws = 1'b0;
    din = 1'b0;
    #7;
    forever #80 bclk = ~bclk;
  end
  always @(negedge bclk) begin
    nxt = pos_q + 5'h01;
    pos_q <= nxt;
    ws <= nxt[4];
    if (nxt[3:0] == 4'h1) begin
      din   <= nxt[4] ? send_r[15] : send_l[15];
      tx_sh <= (nxt[4] ? send_r : send_l) << 1;
    end else begin
      din   <= tx_sh[15];
      tx_sh <= tx_sh << 1;
    end
  end
  // Collects the 16 bits ending where a select edge is seen, so a word sent
  // one bit early shows up shifted
  always @(posedge sclk) begin
    rx_sh <= {rx_sh[14:0], dout};
    ws_q  <= ws_seen;
    if (ws_seen != ws_q) begin
      if (ws_seen) got_l <= {rx_sh[14:0], dout};
      else got_r <= {rx_sh[14:0], dout};
    end
  end
endmodule : i2s_codec_model
`default_nettype wire

// *** dual_i2s_audio_port_tb_top.sv ***
`default_nettype none
module dual_i2s_audio_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] L_WORD = 16'hA5C3;
  localparam logic [15:0] R_WORD = 16'h3C5A;
  localparam logic [15:0] P_L = 16'h9A61;
  localparam logic [15:0] P_R = 16'h0F3C;
  logic mclk = 1'b0, reset_n = 1'b0, host_if_found = 1'b0, map_req = 1'b0;
  logic master_en = 1'b0, mono_en = 1'b0, msb_on_edge = 1'b0, tx_dir = 1'b1;
  logic full_duplex_en = 1'b0, clk_inv = 1'b0, ws_inv = 1'b0, din_inv = 1'b0;
  logic dout_inv = 1'b0, idle_drive_low = 1'b0, idle_clk_stop = 1'b0;
  logic [9:0]  rate_steps = 10'h100;
  logic [7:0]  slot_bits = 8'h10, ws_rise_pos = 8'h10;
  logic [15:0] tx_left = L_WORD, tx_right = R_WORD;
  wire logic   tx_taken, rx_valid, port_live, bclk_ref, bclk_o, bclk_oe_n;
  wire logic   ws_o, ws_oe_n, dout_o, dout_oe_n, p_bclk, p_ws, p_din;
  wire logic [15:0] rx_left, rx_right, got_l, got_r;
  wire logic   link_clk = master_en ? bclk_ref : p_bclk;
  wire logic   ws_i = master_en ? ws_o : p_ws;
  // A released line shows the inverse of the last level, never a lucky match
  wire logic   dout_w = dout_oe_n ? ~dout_o : dout_o;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;

  dual_i2s_audio_port dut (.mclk(mclk), .reset_n(reset_n), .link_clk(link_clk),
    .host_if_found(host_if_found), .map_req(map_req), .master_en(master_en),
    .mono_en(mono_en), .msb_on_edge(msb_on_edge), .full_duplex_en(full_duplex_en),
    .tx_dir(tx_dir), .clk_inv(clk_inv), .ws_inv(ws_inv), .din_inv(din_inv),
    .dout_inv(dout_inv), .rate_steps(rate_steps), .slot_bits(slot_bits),
    .ws_rise_pos(ws_rise_pos), .idle_drive_low(idle_drive_low),
    .idle_clk_stop(idle_clk_stop), .tx_left(tx_left), .tx_right(tx_right),
    .tx_taken(tx_taken), .rx_left(rx_left), .rx_right(rx_right), .rx_valid(rx_valid),
    .port_live(port_live), .bclk_ref(bclk_ref), .bclk_o(bclk_o), .bclk_oe_n(bclk_oe_n),
    .ws_i(ws_i), .ws_o(ws_o), .ws_oe_n(ws_oe_n), .din_i(p_din), .dout_o(dout_o),
    .dout_oe_n(dout_oe_n));
  i2s_codec_model codec (.bclk(p_bclk), .ws(p_ws), .din(p_din), .dout(dout_w),
    .ext_clk(bclk_o), .ext_ws(ws_o), .use_ext(master_en),
    .send_l(P_L), .send_r(P_R), .got_l(got_l), .got_r(got_r));

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  task automatic summarize();
    if (num_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Counts handshake pulses; returns cycles since the previous pulse
  task automatic wait_pulses(input bit rx, input int n, output int gap);
    int cnt;
    int seen;
    cnt = 0;
    seen = 0;
    gap = 0;
    while (seen < n && cnt < 4000) begin
      @(negedge mclk);
      cnt++;
      gap++;
      if ((rx ? rx_valid : tx_taken) === 1'b1) begin
        seen++;
        if (seen < n) gap = 0;
      end
    end
    if (seen < n) begin
      num_errors++;
      $display("FAIL %0t handshake missing", $time);
    end
  endtask : wait_pulses

  // Config changes only while the port is off
  task automatic restart(input logic m, input logic mono, input logic early, input logic dir);
    int cnt;
    @(negedge mclk);
    host_if_found = 1'b0;
    cnt = 0;
    while (port_live !== 1'b0 && cnt < 20) begin
      @(negedge mclk);
      cnt++;
    end
    master_en = m;
    mono_en = mono;
    msb_on_edge = early;
    tx_dir = dir;
    @(negedge mclk);
    host_if_found = 1'b1;
    wait_pulses(!dir, 4, cnt);
  endtask : restart

  task automatic t_reset();
    chk({12'h000, port_live, bclk_oe_n, ws_oe_n, dout_oe_n}, 16'h0007);
  endtask : t_reset

  task automatic t_stereo();
    restart(1'b0, 1'b0, 1'b0, 1'b1);
    chk(got_l, L_WORD);
    chk(got_r, R_WORD);
    chk({15'h0000, dout_oe_n}, 16'h0000);
  endtask : t_stereo

  task automatic t_mono();
    restart(1'b0, 1'b1, 1'b0, 1'b1);
    chk(got_l, L_WORD);
    chk(got_r, L_WORD);
  endtask : t_mono

  task automatic t_msb_edge();
    restart(1'b0, 1'b0, 1'b1, 1'b1);
    chk(got_l, {L_WORD[14:0], R_WORD[15]});
    chk(got_r, {R_WORD[14:0], L_WORD[15]});
  endtask : t_msb_edge

  task automatic t_rx();
    restart(1'b0, 1'b0, 1'b0, 1'b0);
    chk(rx_left, P_L);
    chk(rx_right, P_R);
    chk({15'h0000, dout_oe_n}, 16'h0001);
  endtask : t_rx

  // 256 steps of 8 kHz give 2048 kHz, so a 32-clock frame spans 625 system clocks
  task automatic t_master();
    int gap;
    restart(1'b1, 1'b0, 1'b0, 1'b1);
    wait_pulses(1'b0, 2, gap);
    checks++;
    if (gap < 622 || gap > 628) begin
      num_errors++;
      $display("FAIL %0t frame length %0d", $time, gap);
    end
    chk({14'h0000, bclk_oe_n, ws_oe_n}, 16'h0000);
    chk(got_l, L_WORD);
  endtask : t_master

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      $display("FAIL %0t run too long", $time);
      summarize();
    end
  end

  initial begin
    repeat (20) @(negedge mclk);
    t_reset();
    reset_n = 1'b1;
    repeat (2) @(negedge mclk);
    t_reset();
    t_stereo();
    t_mono();
    t_msb_edge();
    t_rx();
    t_master();
    summarize();
  end
endmodule : dual_i2s_audio_port_tb_top
`default_nettype wire
